// ==== design/dual_wiper_serial_command_unit.sv ====
// Serial command interpreter for a dual 10-bit wiper with nonvolatile backing
`timescale 1ns/1ps
`include "wiper_unit_params.svh"
module dual_wiper_serial_command_unit (
   input  wire logic                I_CLK,
   input  wire logic                I_RESETN,
   input  wire logic                I_SCLK,
   input  wire logic                I_CS_N,
   input  wire logic                I_SDI,
   input  wire logic                I_WP_N,
   input  wire logic                I_NV_RECALL_STROBE_N,
   output logic                     O_SDO,
   output logic                     O_SDO_OE,
   output logic [`TAPS-1:0]         O_CHANNEL_ONE_TAP,
   output logic [`TAPS-1:0]         O_CHANNEL_TWO_TAP,
   output logic                     O_BOTTOM_SWITCH
);
   import wiper_unit_pkg::*;

   unit_state_t            st_r;
   unit_state_t            st_nxt;
   wiper_unit_pkg::pin_t   pins;
   logic                   sclk_rise;
   logic                   sclk_fall;
   logic                   cs_fall;
   logic                   cs_rise;
   logic                   recall_fall;
   logic                   exec_go;
   frame_t                 exec_frame;
   logic                   ch;
   logic [`CODE_W-1:0]     cur;

   assign pins = '{sclk: I_SCLK, cs_n: I_CS_N, sdi: I_SDI, wp_n: I_WP_N,
                   recall_n: I_NV_RECALL_STROBE_N};

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt      = st_r;
      st_nxt.s1   = pins;
      st_nxt.s2   = st_r.s1;
      st_nxt.s3   = st_r.s2;
      // A pin level is taken only once stages two and three agree
      st_nxt.filt = (st_r.s2 & st_r.s3) | (st_r.filt & (st_r.s2 | st_r.s3));
      sclk_rise   = st_nxt.filt.sclk & ~st_r.filt.sclk;
      sclk_fall   = ~st_nxt.filt.sclk & st_r.filt.sclk;
      cs_fall     = ~st_nxt.filt.cs_n & st_r.filt.cs_n;
      cs_rise     = st_nxt.filt.cs_n & ~st_r.filt.cs_n;
      recall_fall = ~st_nxt.filt.recall_n & st_r.filt.recall_n;

      // Serial shifting, data sampled on rising clock, driven on falling
      if (cs_fall) begin
         st_nxt.bit_cnt   = `CNT_ZERO;
         st_nxt.shift_out = st_r.reply;
      end else if (!st_r.filt.cs_n) begin
         if (sclk_rise) begin
            st_nxt.shift_in = {st_r.shift_in[`FRAME_W-2:0], st_r.filt.sdi};
            if (st_r.bit_cnt != `CNT_MAX) begin
               st_nxt.bit_cnt = `CNT_W'(st_r.bit_cnt + `CNT_W'(1));
            end
         end
         if (sclk_fall) begin
            st_nxt.shift_out = {st_r.shift_out[`FRAME_W-2:0], 1'b0};
         end
      end

      // Frames of 1 to 23 bits or longer than 24 bits are dropped; zero bits repeat the last frame
      exec_go    = cs_rise && (st_r.bit_cnt == `FRAME_BITS
                               || st_r.bit_cnt == `CNT_ZERO);
      exec_frame = (st_r.bit_cnt == `CNT_ZERO) ? st_r.last_frame
                                               : frame_t'(st_r.shift_in);
      ch  = exec_frame.addr[0];
      cur = st_r.wiper[ch];

      if (exec_go) begin
         st_nxt.last_frame = exec_frame;
         st_nxt.reply      = exec_frame;
         case (exec_frame.cmd)
            `CMD_RESTORE: begin
               if (exec_frame.addr <= `ADDR_SLOT_TWO) begin
                  st_nxt.wiper[ch] = st_r.nv[exec_frame.addr][`CODE_W-1:0];
               end
            end
            `CMD_STORE: begin
               if (exec_frame.addr <= `ADDR_SLOT_TWO && st_r.filt.wp_n) begin
                  st_nxt.nv[exec_frame.addr] = `DATA_W'(cur);
               end
            end
            `CMD_USER_WR: begin
               if (exec_frame.addr >= `ADDR_USER_LO && exec_frame.addr <= `ADDR_USER_HI
                   && st_r.filt.wp_n) begin
                  st_nxt.nv[exec_frame.addr] = exec_frame.data;
               end
            end
            `CMD_NV_RD: begin
               // Tolerance slot reads back in sign-magnitude form as stored
               st_nxt.reply.data = st_r.nv[exec_frame.addr];
            end
            `CMD_WIPER_RD: begin
               st_nxt.reply.data = `DATA_W'(cur);
            end
            `CMD_WIPER_WR: begin
               st_nxt.wiper[ch] = exec_frame.data[`CODE_W-1:0];
            end
            `CMD_DOUBLE: begin
               if (cur == `CODE_ZERO) begin
                  st_nxt.wiper[ch] = `CODE_ONE;
               end else if (cur >= `CODE_MID) begin
                  st_nxt.wiper[ch] = `CODE_FULL;
               end else begin
                  st_nxt.wiper[ch] = {cur[`CODE_W-2:0], 1'b0};
               end
            end
            `CMD_INC: begin
               if (cur != `CODE_FULL) begin
                  st_nxt.wiper[ch] = `CODE_W'(cur + `CODE_ONE);
               end
            end
            default: begin
               // No-operation and unused commands only echo the frame; wipers and nonvolatile store stay alone
               st_nxt.reply = exec_frame;
            end
         endcase
      end

      // Restore sequence; each step's wiper load overrides a command on that wiper finishing in the same cycle
      case (st_r.state)
         ST_RESTORE_ONE: begin
            st_nxt.wiper[0] = st_r.nv[0][`CODE_W-1:0];
            st_nxt.state    = ST_RESTORE_TWO;
         end
         ST_RESTORE_TWO: begin
            st_nxt.wiper[1] = st_r.nv[1][`CODE_W-1:0];
            st_nxt.state    = ST_IDLE;
         end
         default: begin
            st_nxt.state = ST_IDLE;
         end
      endcase
      if (recall_fall) begin
         st_nxt.state = ST_RESTORE_ONE;
      end

      // Taps track the new code so they change with the wiper register
      st_nxt.tap    = '0;
      st_nxt.tap[0][st_nxt.wiper[0]] = 1'b1;
      st_nxt.tap[1][st_nxt.wiper[1]] = 1'b1;
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         st_r            <= '0;
         st_r.s1         <= `PIN_IDLE;
         st_r.s2         <= `PIN_IDLE;
         st_r.s3         <= `PIN_IDLE;
         st_r.filt       <= `PIN_IDLE;
         st_r.state      <= ST_RESTORE_ONE;
         st_r.nv[`ADDR_TOL] <= `TOLERANCE_WORD;
         st_r.tap[0][0]  <= 1'b1;
         st_r.tap[1][0]  <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign O_SDO             = st_r.shift_out[`FRAME_W-1];
   assign O_SDO_OE          = ~st_r.filt.cs_n;
   assign O_CHANNEL_ONE_TAP = st_r.tap[0];
   assign O_CHANNEL_TWO_TAP = st_r.tap[1];
   assign O_BOTTOM_SWITCH   = 1'b1;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RESETN);

   a_tap_one_hot: assert property ($onehot(O_CHANNEL_ONE_TAP)
                                   && $onehot(O_CHANNEL_TWO_TAP))
      else $error("tap select not one-hot");
   a_tap_code_match: assert property (O_CHANNEL_ONE_TAP[st_r.wiper[0]]
                                      && O_CHANNEL_TWO_TAP[st_r.wiper[1]])
      else $error("tap does not match wiper code");
   a_write_load: assert property (exec_go && exec_frame.cmd == `CMD_WIPER_WR
      && st_r.state == ST_IDLE && !recall_fall
      |=> st_r.wiper[$past(ch)] == $past(exec_frame.data[`CODE_W-1:0])
          && st_r.reply == $past(exec_frame))
      else $error("wiper write or echo wrong");
   a_inc_step: assert property (exec_go && exec_frame.cmd == `CMD_INC && cur != `CODE_FULL
      && st_r.state == ST_IDLE && !recall_fall
      |=> st_r.wiper[$past(ch)] == $past(cur) + `CODE_ONE)
      else $error("increment wrong");
   a_inc_saturate: assert property (exec_go && exec_frame.cmd == `CMD_INC && cur == `CODE_FULL
      && st_r.state == ST_IDLE && !recall_fall |=> st_r.wiper[$past(ch)] == `CODE_FULL)
      else $error("increment wrapped");
   a_double_mid: assert property (exec_go && exec_frame.cmd == `CMD_DOUBLE && cur >= `CODE_MID
      && st_r.state == ST_IDLE && !recall_fall |=> st_r.wiper[$past(ch)] == `CODE_FULL)
      else $error("doubling did not saturate");
   a_double_zero: assert property (exec_go && exec_frame.cmd == `CMD_DOUBLE && cur == `CODE_ZERO
      && st_r.state == ST_IDLE && !recall_fall |=> st_r.wiper[$past(ch)] == `CODE_ONE)
      else $error("doubling zero not one");
   a_protect_store: assert property (exec_go && !st_r.filt.wp_n |=> $stable(st_r.nv))
      else $error("store under write protect");
   a_wiper_read: assert property (exec_go && exec_frame.cmd == `CMD_WIPER_RD
      |=> st_r.reply.data == `DATA_W'($past(cur)) && st_r.reply.cmd == `CMD_WIPER_RD)
      else $error("wiper readback wrong");
   a_nop_still: assert property (exec_go && exec_frame.cmd == `CMD_NOP
      && st_r.state == ST_IDLE && !recall_fall
      |=> $stable(st_r.wiper) && $stable(st_r.nv))
      else $error("no-operation changed state");
   // While select stays low nothing but a restore may touch wipers or store
   a_exec_at_release: assert property ((!st_r.filt.cs_n && st_r.state == ST_IDLE
      && !recall_fall) ##1 !st_r.filt.cs_n
      |-> $stable(st_r.wiper) && $stable(st_r.nv))
      else $error("command acted before select release");
   a_recall_reload: assert property (recall_fall ##1 !recall_fall
      |=> st_r.wiper[0] == $past(st_r.nv[0][`CODE_W-1:0]) ##1
          st_r.wiper[1] == $past(st_r.nv[1][`CODE_W-1:0]))
      else $error("recall did not reload wipers");

   c_write_frame: cover property (exec_go && exec_frame.cmd == `CMD_WIPER_WR);
   c_repeat_strobe: cover property (exec_go && st_r.bit_cnt == `CNT_ZERO);
   c_user_read: cover property (exec_go && exec_frame.cmd == `CMD_NV_RD);
   c_recall: cover property (recall_fall);
endmodule // dual_wiper_serial_command_unit

// ==== common/wiper_unit_params.svh ====
// Constants of the dual wiper serial command unit
// Notes on behaviour
// - Each channel's 10-bit wiper code selects one of 1024 taps.
// - Code 0 sits at bottom terminal; each count moves one tap up.
// - Exactly one tap switch is on; the bottom switch is always on.
// - Command B0/B1 loads data into wiper one/two; next frame echoes it.
// - Command E0 adds one to wiper one; other frame bits ignored.
// - Command 2x copies the addressed wiper into its nonvolatile slot.
// - Command 1x copies the nonvolatile slot back into the wiper.
// - Wipers reload from nonvolatile store at power-on and on recall strobe.
// - Command C0/C1 doubles wiper one/two by a left shift.
// - Doubling midscale 0x200 gives full scale 0x3FF.
// - Command 3 with address 2..14 stores data into a spare word.
// - Command 9x prepares a nonvolatile word; next frame returns it.
// - No-operation changes nothing and shifts out pending 24-bit reply.
// - Command Ax prepares a wiper code; next frame returns it right-justified.
// - Shifting zero gives 1; shifting midscale or above gives full scale.
// - A select strobe with no clocks re-executes the previous command.
// - Tolerance word: sign bit, 7 integer bits, 8 fraction bits.
`ifndef WIPER_UNIT_PARAMS_SVH
`define WIPER_UNIT_PARAMS_SVH

`define FRAME_W      24
`define FRAME_BITS   5'h18
`define CNT_W        5
`define CODE_W       10
`define DATA_W       16
`define NV_DEPTH     16
`define TAPS         1024
`define CODE_ZERO    10'h000
`define CODE_ONE     10'h001
`define CODE_MID     10'h200
`define CODE_FULL    10'h3FF
`define CNT_MAX      5'h1F
`define CNT_ZERO     5'h00

`define CMD_NOP      4'h0
`define CMD_RESTORE  4'h1
`define CMD_STORE    4'h2
`define CMD_USER_WR  4'h3
`define CMD_NV_RD    4'h9
`define CMD_WIPER_RD 4'hA
`define CMD_WIPER_WR 4'hB
`define CMD_DOUBLE   4'hC
`define CMD_INC      4'hE

`define ADDR_USER_LO 4'h2
`define ADDR_USER_HI 4'hE
`define ADDR_SLOT_TWO 4'h1
`define ADDR_TOL     4'hF

// Sign set, 28 + 15/256 percent
`define TOLERANCE_WORD 16'h9C0F
`define PIN_IDLE     5'h0B

`define ST_RESTORE_ONE 2'h0
`define ST_RESTORE_TWO 2'h1
`define ST_IDLE        2'h3

`endif

// ==== common/wiper_unit_pkg.sv ====
// Types of the dual wiper serial command unit
`include "wiper_unit_params.svh"
package wiper_unit_pkg;
   typedef enum logic [1:0] {
      ST_RESTORE_ONE = `ST_RESTORE_ONE,
      ST_RESTORE_TWO = `ST_RESTORE_TWO,
      ST_IDLE        = `ST_IDLE
   } ctl_state_t;

   typedef struct packed {
      logic sclk;
      logic cs_n;
      logic sdi;
      logic wp_n;
      logic recall_n;
   } pin_t;

   typedef struct packed {
      logic [3:0]           cmd;
      logic [3:0]           addr;
      logic [`DATA_W-1:0]   data;
   } frame_t;

   typedef struct packed {
      pin_t                                 s1;
      pin_t                                 s2;
      pin_t                                 s3;
      pin_t                                 filt;
      ctl_state_t                           state;
      logic [`CNT_W-1:0]                    bit_cnt;
      logic [`FRAME_W-1:0]                  shift_in;
      logic [`FRAME_W-1:0]                  shift_out;
      frame_t                               reply;
      frame_t                               last_frame;
      logic [1:0][`CODE_W-1:0]              wiper;
      logic [`NV_DEPTH-1:0][`DATA_W-1:0]    nv;
      logic [1:0][`TAPS-1:0]                tap;
   } unit_state_t;
endpackage

// ==== dv/host_link_model.sv ====
// Host side model that drives frames on the serial command link
`timescale 1ns/1ps
module host_link_model (
   input  wire logic  i_clk,
   input  wire logic  i_sdo,
   output logic       o_sclk,
   output logic       o_cs_n,
   output logic       o_sdi
);
   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_sdi  = 1'b0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(negedge i_clk);
   endtask

   // MSB first under select; zero bits gives a bare select strobe
   task automatic xfer(input logic [23:0] tx, input int nbits, output logic [23:0] rx);
      rx = 24'h000000;
      o_cs_n = 1'b0;
      wait_clk(6);
      for (int i = 0; i < nbits; i++) begin
         o_sdi = tx[23-i];
         wait_clk(5);
         o_sclk = 1'b1;
         rx = {rx[22:0], i_sdo};
         wait_clk(5);
         o_sclk = 1'b0;
      end
      wait_clk(5);
      o_cs_n = 1'b1;
      // Released data line must not keep showing the last bit
      o_sdi = ~o_sdi;
      wait_clk(12);
   endtask
endmodule // host_link_model

// ==== dv/dual_wiper_serial_command_unit_tb.sv ====
// Self-checking bench of the dual wiper serial command unit
`timescale 1ns/1ps
`include "wiper_unit_params.svh"
module dual_wiper_serial_command_unit_tb;
   import wiper_unit_pkg::*;
   logic              I_CLK;
   logic              I_RESETN;
   logic              I_WP_N;
   logic              I_NV_RECALL_STROBE_N;
   logic              sclk, cs_n, sdi, sdo, sdo_oe, bottom;
   logic [`TAPS-1:0]  tap_one, tap_two;
   logic [23:0]       exp_reply, last_frame, rx;
   logic [31:0]       seed;
   logic [23:0]       seq [$];
   logic [3:0]        pick [5] = '{4'hB, 4'hE, 4'hC, 4'hA, 4'h0};
   int                n_errors, n_checks;
   int                wiper [2];
   int                nv [16];

   dual_wiper_serial_command_unit u_dual_wiper_serial_command_unit (
      .I_CLK(I_CLK), .I_RESETN(I_RESETN), .I_SCLK(sclk), .I_CS_N(cs_n), .I_SDI(sdi),
      .I_WP_N(I_WP_N), .I_NV_RECALL_STROBE_N(I_NV_RECALL_STROBE_N), .O_SDO(sdo),
      .O_SDO_OE(sdo_oe), .O_CHANNEL_ONE_TAP(tap_one), .O_CHANNEL_TWO_TAP(tap_two),
      .O_BOTTOM_SWITCH(bottom));
   host_link_model u_host_link_model (
      .i_clk(I_CLK), .i_sdo(sdo), .o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi));

   initial begin
      I_CLK = 1'b0;
      forever #12.5 I_CLK = ~I_CLK;
   end

   // ----------------------------------------
   // Checking and reference model
   // ----------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expd);
      n_checks++;
      if (seen !== expd) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, expd, seen);
      end
   endtask

   function automatic logic [31:0] xorshift(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction

   task automatic model(input logic [23:0] f);
      logic [3:0] c;
      logic [3:0] a;
      int         ch;
      c = f[23:20];
      a = f[19:16];
      ch = a[0];
      exp_reply = f;
      case (c)
         `CMD_RESTORE:  if (a < 4'h2) wiper[ch] = nv[ch] % 1024;
         `CMD_STORE:    if (a < 4'h2 && I_WP_N) nv[ch] = wiper[ch];
         `CMD_USER_WR:  if (a >= 4'h2 && a <= 4'hE && I_WP_N) nv[a] = f[15:0];
         `CMD_NV_RD:    exp_reply[15:0] = 16'(nv[a]);
         `CMD_WIPER_RD: exp_reply[15:0] = 16'(wiper[ch]);
         `CMD_WIPER_WR: wiper[ch] = f[9:0];
         `CMD_DOUBLE: begin
            if (wiper[ch] == 0) wiper[ch] = 1;
            else if (wiper[ch] >= 512) wiper[ch] = 1023;
            else wiper[ch] = 2 * wiper[ch];
         end
         `CMD_INC:      wiper[ch] = wiper[ch] == 1023 ? 1023 : wiper[ch] + 1;
         default: ;
      endcase
   endtask

   task automatic check_taps();
      check("tap one", tap_one === (`TAPS'(1) << wiper[0]), 1'b1);
      check("tap two", tap_two === (`TAPS'(1) << wiper[1]), 1'b1);
      check("bottom switch", bottom, 1'b1);
      check("sdo enable", sdo_oe, 1'b0);
   endtask

   // Reply of a frame is what the previous frame prepared
   task automatic frame(input logic [23:0] f, input logic chk);
      logic [23:0] prev;
      prev = exp_reply;
      u_host_link_model.xfer(f, 24, rx);
      if (chk) check("reply", rx, prev);
      model(f);
      last_frame = f;
      check_taps();
   endtask

   task automatic run_seq();
      foreach (seq[i]) frame(seq[i], 1'b1);
   endtask

   task automatic complete_run();
      $display("Checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      I_RESETN = 1'b0;
      I_WP_N = 1'b1;
      I_NV_RECALL_STROBE_N = 1'b1;
      n_errors = 0;
      n_checks = 0;
      seed = 32'h8BB1;
      exp_reply = 24'h000000;
      last_frame = 24'h000000;
      wiper[0] = 0;
      wiper[1] = 0;
      for (int i = 0; i < 16; i++) nv[i] = 0;
      nv[15] = `TOLERANCE_WORD;
      repeat (12) @(negedge I_CLK);
      I_RESETN = 1'b1;
      repeat (4) @(negedge I_CLK);
      check_taps();
      frame(24'hB00100, 1'b0);
      seq = '{24'hB10200, 24'hE05A5A, 24'hE0FFFF, 24'h200000, 24'hB003FF, 24'hE00000,
              24'hC00000, 24'hB00000, 24'hC00000, 24'hC10000, 24'hB00100, 24'hC00000,
              24'hC00000, 24'h100000, 24'hB10155, 24'h210000, 24'h32AAAA, 24'h335555,
              24'h3E1234, 24'h920000, 24'h000000, 24'h930000, 24'h9F0000, 24'h9E0000,
              24'hA00000, 24'hA10000, 24'h000000};
      run_seq();
      I_WP_N = 1'b0;
      seq = '{24'hB00055, 24'h200000, 24'h33FFFF};
      run_seq();
      I_WP_N = 1'b1;
      seq = '{24'h900000, 24'h930000, 24'hE00000};
      run_seq();
      u_host_link_model.xfer(24'h000000, 0, rx);
      model(last_frame);
      check_taps();
      u_host_link_model.xfer(24'hB00333, 12, rx);
      check_taps();
      frame(24'hB10011, 1'b1);
      I_NV_RECALL_STROBE_N = 1'b0;
      repeat (8) @(negedge I_CLK);
      I_NV_RECALL_STROBE_N = 1'b1;
      repeat (8) @(negedge I_CLK);
      wiper[0] = nv[0];
      wiper[1] = nv[1];
      check_taps();
      for (int i = 0; i < 24; i++) begin
         seed = xorshift(seed);
         frame({pick[seed[2:0] % 5], 3'h0, seed[8], 6'h00, seed[25:16]}, 1'b1);
      end
      frame(24'h000000, 1'b1);
      complete_run();
   end

   initial begin
      repeat (90000) @(posedge I_CLK);
      n_errors++;
      complete_run();
   end
endmodule // dual_wiper_serial_command_unit_tb
